// *** sfps_pkg.sv ***
// Package of constants and types for the serial flash power-on sequencer.
package sfps_pkg;

  // ---------------------------------------------------------------------
  // Timing constants.
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ        = 100_000_000;
  localparam int unsigned READ_PERMIT_US     = 70;
  localparam int unsigned PROG_ERASE_MS      = 3;
  // Least read delay and longest program/erase delay both convert to exact cycle counts, with no rounding.
  localparam int unsigned READ_PERMIT_CYCLES =
    (READ_PERMIT_US * (CLK_FREQ_HZ / 1_000_000) + 0);
  localparam int unsigned PROG_ERASE_CYCLES  =
    (PROG_ERASE_MS * (CLK_FREQ_HZ / 1_000));
  localparam int unsigned DELAY_CNT_W        = 24;

  // ---------------------------------------------------------------------
  // Mode encodings and sequencer states.
  // ---------------------------------------------------------------------
  localparam logic SPI_MODE0 = 1'h0;
  localparam logic SPI_MODE3 = 1'h1;

  typedef enum logic [1:0] {
    SFPS_RESET,
    SFPS_WAIT,
    SFPS_STANDBY,
    SFPS_ACTIVE
  } sfps_state_t;

endpackage

// *** sfps_link_front.sv ***
// Link-side front end: catches chip-select falls and the idle clock level.
module sfps_link_front
  import sfps_pkg::*;
(
  input  wire logic link_clk,
  input  wire logic nrst,
  input  wire logic chip_select_n,
  input  wire logic sck_level,
  output logic      fall_toggle_q,
  output logic      mode_q
);

  // -----------------------------------------------------------------------
  // Chip-select edge capture.
  // -----------------------------------------------------------------------
  // Chip select acts as the clock here, so every fall is seen even when the
  // serial clock stands still; a toggle carries the event to the core.
  always_ff @(negedge chip_select_n or negedge nrst) begin
    if (!nrst) begin
      fall_toggle_q <= 1'h0;
      mode_q        <= SPI_MODE0;
    end else begin
      fall_toggle_q <= ~fall_toggle_q;
      mode_q        <= sck_level ? SPI_MODE3 : SPI_MODE0;
    end
  end

endmodule

// *** sfps_top.sv ***
// Top of the serial flash power-on and reset sequencer.
//
// Notes on behaviour
// - Serial output stays high impedance after power-up and after any reset.
// - Instructions decode only after a chip-select fall seen after reset.
// - Each chip-select fall samples idle clock: high gives mode 3, low mode 0.
// - While power-on reset holds, all operations are off and commands ignored.
// - Program or erase waits for internal delay of at most 3 ms.
// - After the delay, chip select high gives standby, low gives active.
module sfps_top
  import sfps_pkg::*;
#(
  parameter int unsigned READ_CYCLES = READ_PERMIT_CYCLES,
  parameter int unsigned PE_CYCLES   = PROG_ERASE_CYCLES
)
(
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic CE,
  input  wire logic POWER_GOOD,
  input  wire logic CHIP_SELECT_N,
  input  wire logic SCK,
  output logic      SO_OE_N,
  output logic      DECODE_EN,
  output logic      READ_PERMIT,
  output logic      PROG_ERASE_PERMIT,
  output logic      SPI_MODE,
  output logic      STANDBY,
  output logic      ACTIVE
);

  // -----------------------------------------------------------------------
  // Declarations.
  // -----------------------------------------------------------------------
  logic                   fall_tgl;
  logic                   mode_link;
  logic [2:0]             tgl_sync_q;
  logic [1:0]             pg_sync_q;
  logic [1:0]             cs_sync_q;
  logic [1:0]             mode_sync_q;
  logic                   cs_fall;
  logic [DELAY_CNT_W-1:0] cnt_q;
  logic                   armed_q;
  sfps_state_t            state_q;
  sfps_state_t            state_d;
  logic                   in_reset;

  // -----------------------------------------------------------------------
  // Link domain.
  // -----------------------------------------------------------------------
  // The chip-select front runs on the chip-select edge itself.
  sfps_link_front u_front (
    .link_clk      (CHIP_SELECT_N),
    .nrst          (NRST),
    .chip_select_n (CHIP_SELECT_N),
    .sck_level     (SCK),
    .fall_toggle_q (fall_tgl),
    .mode_q        (mode_link)
  );

  // -----------------------------------------------------------------------
  // Synchronisers.
  // -----------------------------------------------------------------------
  // Power good, chip select, the link mode and the link toggle pass two flip-flops before use.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tgl_sync_q  <= 3'h0;
      pg_sync_q   <= 2'h0;
      cs_sync_q   <= 2'h3;
      mode_sync_q <= 2'h0;
    end else if (CE) begin
      tgl_sync_q  <= {tgl_sync_q[1:0], fall_tgl};
      pg_sync_q   <= {pg_sync_q[0], POWER_GOOD};
      cs_sync_q   <= {cs_sync_q[0], CHIP_SELECT_N};
      mode_sync_q <= {mode_sync_q[0], mode_link};
    end
  end

  // A change of the synchronised toggle marks one chip-select fall.
  assign cs_fall  = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign in_reset = !pg_sync_q[1];

  // -----------------------------------------------------------------------
  // Permit delay counter.
  // -----------------------------------------------------------------------
  // Counting restarts whenever power good drops.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_q <= '0;
    end else if (CE) begin
      if (in_reset) begin
        cnt_q <= '0;
      end else if (cnt_q < DELAY_CNT_W'(PE_CYCLES)) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Sequencer state.
  // -----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      SFPS_RESET: begin
        if (!in_reset) begin
          state_d = SFPS_WAIT;
        end
      end
      SFPS_WAIT: begin
        if (cnt_q >= DELAY_CNT_W'(PE_CYCLES)) begin
          state_d = cs_sync_q[1] ? SFPS_STANDBY : SFPS_ACTIVE;
        end
      end
      SFPS_STANDBY, SFPS_ACTIVE: begin
        state_d = cs_sync_q[1] ? SFPS_STANDBY : SFPS_ACTIVE;
      end
      default: begin
        state_d = SFPS_RESET;
      end
    endcase
    if (in_reset) begin
      state_d = SFPS_RESET;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= SFPS_RESET;
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------------------------
  // Instruction arming.
  // -----------------------------------------------------------------------
  // Decode waits for a fresh chip-select fall; a fall in the reset cycle
  // itself is dropped since commands are ignored then.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      armed_q <= 1'h0;
    end else if (CE) begin
      if (in_reset) begin
        armed_q <= 1'h0;
      end else if (cs_fall) begin
        armed_q <= 1'h1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Registered outputs.
  // -----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SO_OE_N           <= 1'h1;
      DECODE_EN         <= 1'h0;
      READ_PERMIT       <= 1'h0;
      PROG_ERASE_PERMIT <= 1'h0;
      SPI_MODE          <= SPI_MODE0;
      STANDBY           <= 1'h0;
      ACTIVE            <= 1'h0;
    end else if (CE) begin
      // Output stays released until a command may be decoded and CS is low.
      SO_OE_N           <= in_reset || !armed_q || cs_sync_q[1];
      DECODE_EN         <= !in_reset && armed_q && !cs_sync_q[1];
      READ_PERMIT       <= !in_reset && cnt_q >= DELAY_CNT_W'(READ_CYCLES);
      PROG_ERASE_PERMIT <= !in_reset && cnt_q >= DELAY_CNT_W'(PE_CYCLES);
      if (cs_fall) begin
        SPI_MODE <= mode_sync_q[1];
      end
      STANDBY           <= state_d == SFPS_STANDBY;
      ACTIVE            <= state_d == SFPS_ACTIVE;
    end
  end

endmodule

// *** sfps_chk.sv ***
// Port checker of the power-on sequencer.
module sfps_chk #(
  parameter int unsigned READ_CYCLES = 20,
  parameter int unsigned PE_CYCLES   = 50
)(
  input wire logic CLK, NRST, CE, POWER_GOOD, CHIP_SELECT_N, SCK,
  input wire logic SO_OE_N, DECODE_EN, READ_PERMIT, PROG_ERASE_PERMIT,
  input wire logic SPI_MODE, STANDBY, ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic [31:0] cnt_q;
  // Counts enabled cycles with power good held; the permit time base.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) cnt_q <= 32'h0;
    else if (!POWER_GOOD) cnt_q <= 32'h0;
    else if (CE) cnt_q <= cnt_q + 32'h1;
  end
  sequence pg_lost_s; (!POWER_GOOD && CE) [*4]; endsequence
  sequence cs_still_s; (POWER_GOOD && $stable(CHIP_SELECT_N)) [*8]; endsequence
  // A chip-select fall seen at the core clock, with power good and enable up.
  sequence cs_fall_s; POWER_GOOD && CE && $fell(CHIP_SELECT_N); endsequence
  // Toggle takes two flops plus the detector flop; the mode lands three edges on.
  property mode_p;
    cs_fall_s |-> ##3 SPI_MODE == $past(SCK, 3);
  endproperty
  AST_SO_HIZ: assert property (!DECODE_EN && !$past(DECODE_EN) |-> SO_OE_N)
    else $error("output enabled without decode");
  AST_DEC_FALL: assert property ($rose(DECODE_EN) |-> !$past(CHIP_SELECT_N, 3))
    else $error("decode without chip select fall");
  AST_MODE: assert property (mode_p)
    else $error("mode differs from idle clock");
  AST_POR_OFF: assert property (pg_lost_s |-> SO_OE_N && !(DECODE_EN || ACTIVE
    || READ_PERMIT || PROG_ERASE_PERMIT || STANDBY)) else $error("active in reset");
  AST_READ_TIME: assert property ((POWER_GOOD && cnt_q < READ_CYCLES + 2 |-> !READ_PERMIT)
    and (cnt_q > READ_CYCLES + 5 |-> READ_PERMIT)) else $error("read permit time");
  AST_PE_TIME: assert property ((POWER_GOOD && cnt_q < PE_CYCLES + 2 |-> !PROG_ERASE_PERMIT)
    and (cnt_q > PE_CYCLES + 5 |-> PROG_ERASE_PERMIT)) else $error("erase permit time");
  AST_STATE: assert property (cs_still_s ##0 PROG_ERASE_PERMIT |->
    ACTIVE == !CHIP_SELECT_N && STANDBY == CHIP_SELECT_N) else $error("bad state");
endmodule
bind sfps_top sfps_chk #(.READ_CYCLES(READ_CYCLES), .PE_CYCLES(PE_CYCLES)) chk_u (
  .CLK(CLK), .NRST(NRST), .CE(CE), .POWER_GOOD(POWER_GOOD), .SCK(SCK),
  .CHIP_SELECT_N(CHIP_SELECT_N), .SO_OE_N(SO_OE_N), .DECODE_EN(DECODE_EN),
  .READ_PERMIT(READ_PERMIT), .PROG_ERASE_PERMIT(PROG_ERASE_PERMIT),
  .SPI_MODE(SPI_MODE), .STANDBY(STANDBY), .ACTIVE(ACTIVE));

// *** sfps_host.sv ***
// Host model: frames chip select and clocks the link at 6 ns.
module sfps_host (
  input  wire logic go,
  input  wire logic mode3,
  output logic      cs_n,
  output logic      sck
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cs_n = 1'b1;
  initial sck = 1'b0;
  // Idle level is set before the fall; the clock runs only in the frame.
  always @(posedge go) begin
    sck = mode3;
    #20 cs_n = 1'b0;
    #80 repeat (16) #3 sck = ~sck;
    #40 cs_n = 1'b1;
  end
endmodule

// *** test_serial_flash_power_on_sequencer.sv ***
// Self-checking bench of the power-on sequencer.
module test_serial_flash_power_on_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 20;
  localparam int PC = 50;
  logic clk = 1'b0, nrst = 1'b0, pg = 1'b0, go = 1'b0, m3 = 1'b0, ce = 1'b1;
  logic cs_n, sck, oe_n, dec, rdp, pep, mode, stby, act;
  int n_fail = 0, checks = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  sfps_host host_u (.go(go), .mode3(m3), .cs_n(cs_n), .sck(sck));
  sfps_top #(.READ_CYCLES(RC), .PE_CYCLES(PC)) dut_u (.CLK(clk), .NRST(nrst),
    .CE(ce), .POWER_GOOD(pg), .CHIP_SELECT_N(cs_n), .SCK(sck), .SO_OE_N(oe_n),
    .DECODE_EN(dec), .READ_PERMIT(rdp), .PROG_ERASE_PERMIT(pep), .SPI_MODE(mode),
    .STANDBY(stby), .ACTIVE(act));
  task automatic chk(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: level differs", $time);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One host frame; live says whether the device should answer it.
  task automatic frame(input logic m, input logic live);
    m3 = m;
    go = 1'b1;
    tick(12);
    chk(dec, live);
    chk(oe_n, !live);
    chk(act, live);
    if (live) chk(mode, m);
    go = 1'b0;
    tick(16);
    chk(stby, live);
  endtask
  // Reset phase, a frame ignored in reset, then both permit delays.
  task automatic test_power_up;
    tick(16);
    chk(oe_n, 1'b1);
    chk(dec | rdp | pep | stby | act, 1'b0);
    chk(mode, 1'b0);
    nrst = 1'b1;
    frame(1'b1, 1'b0);
    pg = 1'b1;
    tick(RC);
    chk(rdp, 1'b0);
    tick(6);
    chk(rdp, 1'b1);
    chk(pep, 1'b0);
    tick(PC - RC);
    chk(pep & stby & !dec, 1'b1);
    $display("power-up test done");
  endtask
  // Frames alternate the idle clock level so every mode change is seen.
  task automatic test_modes;
    for (int i = 0; i < 3; i++) frame(i[0], 1'b1);
    $display("mode test done");
  endtask
  // Power good drops and returns; decode must wait for a new fall.
  task automatic test_power_loss;
    pg = 1'b0;
    tick(6);
    chk(rdp | pep | stby, 1'b0);
    pg = 1'b1;
    tick(PC + 6);
    chk(dec, 1'b0);
    frame(1'b1, 1'b1);
    $display("power loss test done");
  endtask
  // Mid-run reset clears the mode, so a mode 3 frame proves the update.
  task automatic test_second_reset;
    nrst = 1'b0;
    tick(2);
    chk(oe_n, 1'b1);
    chk(mode, 1'b0);
    nrst = 1'b1;
    tick(PC + 6);
    chk(stby & !dec, 1'b1);
    frame(1'b1, 1'b1);
    $display("second reset test done");
  endtask
  // Enable low freezes the state through a power loss; it acts once enabled.
  task automatic test_clock_enable;
    ce = 1'b0;
    pg = 1'b0;
    tick(8);
    chk(stby & pep, 1'b1);
    ce = 1'b1;
    tick(4);
    chk(stby | pep, 1'b0);
    pg = 1'b1;
    tick(PC + 6);
    chk(pep & stby, 1'b1);
    $display("clock enable test done");
  endtask
  initial begin
    test_power_up;
    test_modes;
    test_power_loss;
    test_second_reset;
    test_clock_enable;
    close_out;
  end
  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      close_out;
    end
  end
endmodule
